// [hdl/sense_io_regs.vh]
// Notes on behaviour
// - By default the presence line gates transmit power, on only during presence.
// - The auxiliary line drives nothing; it is only reported to the host.
// - When enabled, input change reports leave like tag identifier messages.
// - I/O status query replies with output mode, output state and input codes.
// - Input inversion: one command disables it (default), another enables it.
// - Predefined output mode (default) pulses both outputs on each unique tag.
// - No output pulse for transmit-all or buffer-all tags, or in Wiegand mode.
// - The output pulse length is set by a dedicated duration command.
// - Output commands leave predefined mode; code 0 both off, 3 both on.
// - Under host control tag reads never pulse the outputs; only 621 returns.
// - Serial port defaults to 9600 baud, 8 data bits, 1 stop, no parity.
// - Defaults are the basic protocol and software XON/XOFF flow control.
// - Separate commands set baud rate, stop bits and parity.
// - One command selects basic protocol (default), another error correcting.
// - Software flow control: stop on XOFF, resume only on XON.
// - Hardware flow control: stop while CTS deasserted, resume when asserted.
// - Flow control command: 0 none, 1 XON/XOFF (default), 2 CTS.
// - Command mode entry answers done; another command returns to data mode.
// - Change reports: 1 presence, 2 auxiliary, 3 either, 0 off (default).
`ifndef SENSE_IO_REGS_VH
`define SENSE_IO_REGS_VH

// Register byte offsets
`define ADDR_CMD 5'h00
`define ADDR_STATUS 5'h04
`define ADDR_REPLY 5'h08
`define ADDR_CONFIG 5'h0C

// Status bit positions
`define ST_CMD_MODE 0
`define ST_DONE 1
`define ST_ERR 2
`define ST_REPLY 3

// Command words, one hex digit per decimal command digit
`define CMD_DATA_MODE 16'h0000
`define CMD_CMD_MODE 16'h0001
`define CMD_IO_STATUS 16'h0526
`define CMD_BASIC 16'h0610
`define CMD_ECP 16'h0611
`define CMD_PREDEF 16'h0621
`define CMD_INV_OFF 16'h6940
`define CMD_INV_ON 16'h6941

// Reset values
`define BAUD_RST 4'h6
`define STOP_RST 4'h0
`define PARITY_RST 4'h0
`define FLOW_RST 2'h1
`define PULSE_RST 4'h0

// Flow control codes and characters
`define FLOW_NONE 2'h0
`define FLOW_SW 2'h1
`define FLOW_HW 2'h2
`define CHAR_XOFF 8'h13
`define CHAR_XON 8'h11

// Timing
`define CLK_MHZ 200
`define DEBOUNCE_US 1000
`define DEBOUNCE_CYC (`DEBOUNCE_US * `CLK_MHZ)
`define PULSE_UNIT_MS 10
`define PULSE_UNIT_CYC (`PULSE_UNIT_MS * 1000 * `CLK_MHZ)

`endif

// [hdl/sense_io_serial_flow_ctrl.v]
`timescale 1ns/10ps
`default_nettype none
`include "sense_io_regs.vh"

module sense_io_serial_flow_ctrl #(
   parameter [31:0] DEBOUNCE_CYCLES = `DEBOUNCE_CYC,
   parameter [31:0] PULSE_UNIT_CYCLES = `PULSE_UNIT_CYC
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   // AXI4-Lite slave
   input wire [4:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [4:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Dry-contact pins
   input wire presenceSenseLine,
   input wire auxiliarySenseLine,
   input wire ctsN,
   // Tag reader events
   input wire tagValid,
   input wire tagUnique,
   input wire tagAllMode,
   input wire wiegandMode,
   // Received serial characters
   input wire rxCharValid,
   input wire [7:0] rxChar,
   // Outputs
   output reg txPowerOn,
   output reg firstIndicatorOutput,
   output reg secondIndicatorOutput,
   output reg txAllow,
   output reg reportStrobe,
   output reg [1:0] reportCode,
   output reg [3:0] baudCode,
   output reg [3:0] stopCode,
   output reg [3:0] parityCode,
   output reg ecpEnable,
   output reg [1:0] flowMode
);

   // ---------------------------------------------------------------
   // Input synchronisers and debounce
   // ---------------------------------------------------------------
   reg [1:0] syncA;
   reg [1:0] syncB;
   reg ctsA;
   reg ctsB;
   wire [1:0] stable;

   always @(posedge clk) begin
      if (rst) begin
         syncA <= 2'h0;
         syncB <= 2'h0;
         ctsA <= 1'b1;
         ctsB <= 1'b1;
      end else begin
         syncA <= {auxiliarySenseLine, presenceSenseLine};
         syncB <= syncA;
         ctsA <= ctsN;
         ctsB <= ctsA;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : deb
         reg [31:0] cnt;
         reg level;
         assign stable[g] = level;
         // A new level must hold for the full window; bounce restarts it
         always @(posedge clk) begin
            if (rst) begin
               cnt <= 32'h0000_0000;
               level <= 1'b0;
            end else if (syncB[g] == level) begin
               cnt <= 32'h0000_0000;
            end else if (cnt >= DEBOUNCE_CYCLES - 32'h0000_0001) begin
               cnt <= 32'h0000_0000;
               level <= syncB[g];
            end else begin
               cnt <= cnt + 32'h0000_0001;
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Configuration state
   // ---------------------------------------------------------------
   reg cmdMode;
   reg doneAck;
   reg cmdErr;
   reg replyValid;
   reg [4:0] reply;
   reg invert;
   reg hostMode;
   reg [1:0] hostOut;
   reg [3:0] pulseCode;
   reg [1:0] reportMode;
   reg xoffSeen;

   wire [1:0] sensed = stable ^ {2{invert}};

   // ---------------------------------------------------------------
   // AXI4-Lite write path
   // ---------------------------------------------------------------
   reg awHeld;
   reg wHeld;
   reg [4:0] awAddr;
   reg [31:0] wData;
   wire doWrite = awHeld && wHeld && !s_axi_bvalid;
   wire [15:0] cmd = wData[15:0];
   wire cmdWrite = doWrite && (awAddr == `ADDR_CMD);
   wire stWrite = doWrite && (awAddr == `ADDR_STATUS) && s_axi_wstrb[0];
   wire mapped = (awAddr == `ADDR_CMD) || (awAddr == `ADDR_STATUS) ||
      (awAddr == `ADDR_REPLY) || (awAddr == `ADDR_CONFIG);

   always @(posedge clk) begin
      if (rst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddr <= 5'h00;
         wData <= 32'h0000_0000;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            s_axi_wready <= 1'b0;
         end
         if (doWrite) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped ? 2'h0 : 2'h2;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Command interpreter
   // ---------------------------------------------------------------
   // Serial port, protocol, flow control and mode switch commands act in either mode; the rest need command mode
   always @(posedge clk) begin
      if (rst) begin
         cmdMode <= 1'b0;
         doneAck <= 1'b0;
         cmdErr <= 1'b0;
         replyValid <= 1'b0;
         reply <= 5'h00;
         invert <= 1'b0;
         hostMode <= 1'b0;
         hostOut <= 2'h0;
         pulseCode <= `PULSE_RST;
         reportMode <= 2'h0;
         baudCode <= `BAUD_RST;
         stopCode <= `STOP_RST;
         parityCode <= `PARITY_RST;
         ecpEnable <= 1'b0;
         flowMode <= `FLOW_RST;
      end else begin
         // Write-one-to-clear; a same-cycle set below wins
         if (stWrite) begin
            doneAck <= doneAck & ~wData[`ST_DONE];
            cmdErr <= cmdErr & ~wData[`ST_ERR];
            replyValid <= replyValid & ~wData[`ST_REPLY];
         end
         if (cmdWrite) begin
            casez (cmd)
               `CMD_CMD_MODE: begin
                  cmdMode <= 1'b1;
                  doneAck <= 1'b1;
               end
               `CMD_DATA_MODE: cmdMode <= 1'b0;
               16'h100?: baudCode <= cmd[3:0];
               16'h101?: stopCode <= cmd[3:0];
               16'h102?: parityCode <= cmd[3:0];
               `CMD_BASIC: ecpEnable <= 1'b0;
               `CMD_ECP: ecpEnable <= 1'b1;
               16'h614?: begin
                  if (cmd[3:0] <= 4'h2)
                     flowMode <= cmd[1:0];
                  else
                     cmdErr <= 1'b1;
               end
               default: begin
                  if (!cmdMode) begin
                     cmdErr <= 1'b1;
                  end else begin
                     casez (cmd)
                        `CMD_INV_OFF: invert <= 1'b0;
                        `CMD_INV_ON: invert <= 1'b1;
                        `CMD_PREDEF: hostMode <= 1'b0;
                        16'h620?: begin
                           if (cmd[3:0] <= 4'h3) begin
                              hostMode <= 1'b1;
                              hostOut <= cmd[1:0];
                           end else begin
                              cmdErr <= 1'b1;
                           end
                        end
                        16'h067?: pulseCode <= cmd[3:0];
                        16'h082?: begin
                           if (cmd[3:0] <= 4'h3)
                              reportMode <= cmd[1:0];
                           else
                              cmdErr <= 1'b1;
                        end
                        `CMD_IO_STATUS: begin
                           reply <= {~hostMode, sensed, hostOut};
                           replyValid <= 1'b1;
                        end
                        default: cmdErr <= 1'b1;
                     endcase
                  end
               end
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Indicator outputs
   // ---------------------------------------------------------------
   reg [4:0] pulseLeft;
   reg [31:0] unitCnt;
   wire trigger = tagValid && tagUnique && !hostMode &&
      !tagAllMode && !wiegandMode;

   always @(posedge clk) begin
      if (rst) begin
         pulseLeft <= 5'h00;
         unitCnt <= 32'h0000_0000;
         firstIndicatorOutput <= 1'b0;
         secondIndicatorOutput <= 1'b0;
      end else begin
         if (trigger) begin
            pulseLeft <= {1'b0, pulseCode} + 5'h01;
            unitCnt <= 32'h0000_0000;
         end else if (hostMode) begin
            pulseLeft <= 5'h00;
         end else if (pulseLeft != 5'h00) begin
            if (unitCnt >= PULSE_UNIT_CYCLES - 32'h0000_0001) begin
               unitCnt <= 32'h0000_0000;
               pulseLeft <= pulseLeft - 5'h01;
            end else begin
               unitCnt <= unitCnt + 32'h0000_0001;
            end
         end
         firstIndicatorOutput <= hostMode ? hostOut[0] :
            (pulseLeft != 5'h00);
         secondIndicatorOutput <= hostMode ? hostOut[1] :
            (pulseLeft != 5'h00);
      end
   end

   // ---------------------------------------------------------------
   // Power gating, change reports, flow control
   // ---------------------------------------------------------------
   reg [1:0] prevSensed;
   // Each line takes part when its reportMode bit is set; presence is bit 0
   wire [1:0] changed = (sensed ^ prevSensed) & reportMode;

   always @(posedge clk) begin
      if (rst) begin
         txPowerOn <= 1'b0;
         prevSensed <= 2'h0;
         reportStrobe <= 1'b0;
         reportCode <= 2'h0;
         xoffSeen <= 1'b0;
         txAllow <= 1'b1;
      end else begin
         txPowerOn <= sensed[0];
         prevSensed <= sensed;
         // Reports go out in data mode only, through the tag message path
         reportStrobe <= (changed != 2'h0) && !cmdMode;
         reportCode <= sensed;
         if (flowMode != `FLOW_SW)
            xoffSeen <= 1'b0;
         else if (rxCharValid && rxChar == `CHAR_XOFF)
            xoffSeen <= 1'b1;
         else if (rxCharValid && rxChar == `CHAR_XON)
            xoffSeen <= 1'b0;
         case (flowMode)
            `FLOW_SW: txAllow <= !xoffSeen;
            `FLOW_HW: txAllow <= !ctsB;
            default: txAllow <= 1'b1;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // AXI4-Lite read path
   // ---------------------------------------------------------------
   reg [31:0] readMux;

   always @* begin
      readMux = 32'h0000_0000;
      case (s_axi_araddr)
         `ADDR_STATUS:
            readMux = {24'h00_0000, hostMode, stable[1], stable[0],
               txAllow, replyValid, cmdErr, doneAck, cmdMode};
         `ADDR_REPLY: readMux = {27'h000_0000, reply};
         `ADDR_CONFIG:
            readMux = {10'h000, pulseCode, reportMode, invert, flowMode,
               ecpEnable, parityCode, stopCode, baudCode};
         default: readMux = 32'h0000_0000;
      endcase
   end

   always @(posedge clk) begin
      if (rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= readMux;
         s_axi_rresp <= (s_axi_araddr == `ADDR_CMD ||
            s_axi_araddr == `ADDR_STATUS || s_axi_araddr == `ADDR_REPLY ||
            s_axi_araddr == `ADDR_CONFIG) ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule
`default_nettype wire

// [verif/host_link.sv]
`timescale 1ns/10ps
`default_nettype none
module host_link (
   // Clock
   input wire logic clk,
   // Serial side toward the block
   output logic rxCharValid,
   output logic [7:0] rxChar,
   output logic ctsN
);
   initial begin
      rxCharValid = 1'b0;
      rxChar = 8'h00;
      ctsN = 1'b0;
   end
   // Inverted after use so a stale character never looks valid
   task automatic send_char(input logic [7:0] c);
      @(posedge clk);
      rxCharValid <= 1'b1;
      rxChar <= c;
      @(posedge clk);
      rxCharValid <= 1'b0;
      rxChar <= ~c;
   endtask
   task automatic set_cts(input logic on);
      @(posedge clk);
      ctsN <= ~on;
   endtask
endmodule
`default_nettype wire

// [verif/sense_io_props.sv]
`timescale 1ns/10ps
`default_nettype none
module sense_io_props #(
   parameter [31:0] DEBOUNCE_CYCLES = 32'h0000_0004,
   parameter [31:0] PULSE_UNIT_CYCLES = 32'h0000_0008
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic rxCharValid,
   input wire logic [7:0] rxChar,
   input wire logic ctsN,
   input wire logic txAllow,
   input wire logic reportStrobe,
   input wire logic [1:0] flowMode,
   input wire logic [3:0] baudCode,
   input wire logic [3:0] stopCode,
   input wire logic [3:0] parityCode,
   input wire logic ecpEnable,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence xoff_in;
      rxCharValid && rxChar == 8'h13 && flowMode == 2'h1;
   endsequence
   sequence no_xon_low;
      flowMode == 2'h1 && !(rxCharValid && rxChar == 8'h11)
      ##1 flowMode == 2'h1 && !txAllow;
   endsequence
   reset_cfg_a: assert property ($past(rst) |-> baudCode == 4'h6
      && stopCode == 4'h0 && parityCode == 4'h0 && !ecpEnable
      && flowMode == 2'h1) else $error("defaults lost after reset");
   xoff_stop_a: assert property (xoff_in ##1 flowMode == 2'h1
      |-> ##1 !txAllow) else $error("XOFF did not stop sending");
   xon_only_a: assert property (no_xon_low
      |=> !txAllow || flowMode != 2'h1) else $error("resumed without XON");
   flow_none_a: assert property (flowMode == 2'h0 [*3]
      |-> txAllow) else $error("sending held with no flow control");
   cts_stop_a: assert property ((flowMode == 2'h2 && ctsN) [*5]
      |-> !txAllow) else $error("sending while CTS deasserted");
   cts_go_a: assert property ((flowMode == 2'h2 && !ctsN) [*5]
      |-> txAllow) else $error("held while CTS asserted");
   strobe_pulse_a: assert property (reportStrobe |=> !reportStrobe)
      else $error("report strobe longer than a cycle");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
endmodule
bind sense_io_serial_flow_ctrl sense_io_props #(
   .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES),
   .PULSE_UNIT_CYCLES(PULSE_UNIT_CYCLES)
) props (.clk, .rst, .rxCharValid, .rxChar, .ctsN, .txAllow, .reportStrobe,
   .flowMode, .baudCode, .stopCode, .parityCode, .ecpEnable, .s_axi_bvalid,
   .s_axi_bready, .s_axi_bresp);
`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [4:0] s_axi_awaddr = 5'h00;
   logic [4:0] s_axi_araddr = 5'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic presenceSenseLine = 1'b0;
   logic auxiliarySenseLine = 1'b0;
   logic tagValid = 1'b0;
   logic tagUnique = 1'b0;
   logic tagAllMode = 1'b0;
   logic wiegandMode = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, ctsN, rxCharValid, txPowerOn, txAllow, reportStrobe;
   logic ecpEnable, firstIndicatorOutput, secondIndicatorOutput;
   logic [1:0] s_axi_bresp, s_axi_rresp, reportCode, flowMode, r;
   logic [31:0] s_axi_rdata, d;
   logic [7:0] rxChar;
   logic [3:0] baudCode, stopCode, parityCode;
   int nErrors = 0;
   int compares = 0;
   int n;
   always #2.5 clk = ~clk;
   sense_io_serial_flow_ctrl #(.DEBOUNCE_CYCLES(32'h0000_0004),
      .PULSE_UNIT_CYCLES(32'h0000_0008)) uut (.clk, .rst, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .presenceSenseLine, .auxiliarySenseLine, .ctsN, .tagValid, .tagUnique,
      .tagAllMode, .wiegandMode, .rxCharValid, .rxChar, .txPowerOn,
      .firstIndicatorOutput, .secondIndicatorOutput, .txAllow, .reportStrobe,
      .reportCode, .baudCode, .stopCode, .parityCode, .ecpEnable, .flowMode);
   host_link host (.clk, .rxCharValid, .rxChar, .ctsN);
   task automatic check(input string nm, input logic [31:0] e, g);
      compares++;
      if (g !== e) begin
         nErrors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] v);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 50);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n >= 50) nErrors++;
   endtask
   task automatic rd(input string nm, input logic [4:0] a,
         input logic [31:0] e, input logic [1:0] er);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 50);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n >= 50) nErrors++;
      check(nm, e, d);
      check("read response", 32'(er), 32'(r));
   endtask
   // Host outputs follow one edge after the write lands, so allow two
   task automatic cmd(input logic [15:0] w);
      wr(5'h00, {16'h0000, w});
      check("command response", 32'h0000_0000, 32'(r));
      tick(2);
   endtask
   task automatic pins(input logic p, a);
      @(posedge clk);
      presenceSenseLine <= p;
      auxiliarySenseLine <= a;
      tick(12);
   endtask
   task automatic tag(input logic allMode, wieg);
      @(posedge clk);
      tagValid <= 1'b1;
      tagUnique <= 1'b1;
      tagAllMode <= allMode;
      wiegandMode <= wieg;
      @(posedge clk);
      tagValid <= 1'b0;
      tagUnique <= 1'b0;
   endtask
   task automatic ind(input logic [1:0] e);
      check("indicators", 32'(e),
         32'({secondIndicatorOutput, firstIndicatorOutput}));
   endtask
   task automatic complete_run;
      if (nErrors == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      #200000;
      nErrors++;
      complete_run();
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd("config", 5'h0c, 32'h0000_2006, 2'h0);
      check("power", 32'h0000_0000, 32'(txPowerOn));
      rd("unmapped", 5'h10, 32'h0000_0000, 2'h2);
      cmd(16'h0526);
      rd("status", 5'h04, 32'h0000_0014, 2'h0);
      cmd(16'h0001);
      rd("status", 5'h04, 32'h0000_0017, 2'h0);
      s_axi_wstrb <= 4'h0;
      wr(5'h04, 32'h0000_0006);
      rd("status no strobe", 5'h04, 32'h0000_0017, 2'h0);
      s_axi_wstrb <= 4'hf;
      wr(5'h04, 32'h0000_0006);
      rd("status cleared", 5'h04, 32'h0000_0011, 2'h0);
      cmd(16'h1003);
      cmd(16'h1011);
      cmd(16'h1022);
      check("port", 32'h0000_0213, {20'h0_0000, parityCode, stopCode,
         baudCode});
      wr(5'h14, 32'h0000_0001);
      check("unmapped write", 32'h0000_0002, 32'(r));
      host.send_char(8'h13);
      tick(3);
      check("xoff", 32'h0000_0000, 32'(txAllow));
      host.send_char(8'h41);
      tick(3);
      check("other char", 32'h0000_0000, 32'(txAllow));
      host.send_char(8'h11);
      tick(3);
      check("xon", 32'h0000_0001, 32'(txAllow));
      cmd(16'h6142);
      host.set_cts(1'b0);
      tick(8);
      check("cts off", 32'h0000_0000, 32'(txAllow));
      host.set_cts(1'b1);
      tick(8);
      check("cts on", 32'h0000_0001, 32'(txAllow));
      host.set_cts(1'b0);
      cmd(16'h6140);
      tick(4);
      check("no flow", 32'h0000_0001, 32'(txAllow));
      host.set_cts(1'b1);
      cmd(16'h0611);
      check("ecp on", 32'h0000_0001, 32'(ecpEnable));
      cmd(16'h0610);
      check("ecp off", 32'h0000_0000, 32'(ecpEnable));
      pins(1'b1, 1'b0);
      check("power", 32'h0000_0001, 32'(txPowerOn));
      pins(1'b1, 1'b1);
      check("power aux", 32'h0000_0001, 32'(txPowerOn));
      cmd(16'h0526);
      rd("reply", 5'h08, 32'h0000_001c, 2'h0);
      cmd(16'h6941);
      tick(8);
      check("inverted", 32'h0000_0000, 32'(txPowerOn));
      cmd(16'h6940);
      tick(8);
      tag(1'b0, 1'b0);
      tick(2);
      ind(2'h3);
      tick(12);
      ind(2'h0);
      cmd(16'h0672);
      tag(1'b0, 1'b0);
      tick(18);
      ind(2'h3);
      tick(12);
      ind(2'h0);
      @(posedge clk);
      tagValid <= 1'b1;
      @(posedge clk);
      tagValid <= 1'b0;
      tick(3);
      ind(2'h0);
      tag(1'b1, 1'b0);
      tick(3);
      ind(2'h0);
      tag(1'b0, 1'b1);
      tick(3);
      ind(2'h0);
      for (int c = 3; c >= 0; c--) begin
         cmd(16'h6200 + 16'(c));
         ind(2'(c));
      end
      tag(1'b0, 1'b0);
      tick(3);
      ind(2'h0);
      cmd(16'h0621);
      tag(1'b0, 1'b0);
      tick(2);
      ind(2'h3);
      cmd(16'h0823);
      cmd(16'h0000);
      @(posedge clk);
      auxiliarySenseLine <= 1'b0;
      for (int k = 0; k < 40 && reportStrobe !== 1'b1; k++) tick(1);
      check("report", 32'h0000_0001, 32'(reportStrobe));
      check("report code", 32'h0000_0001, 32'(reportCode));
      complete_run();
   end
endmodule
`default_nettype wire
